// *** verilog/dbe_defines.svh ***
`ifndef DBE_DEFINES_SVH
`define DBE_DEFINES_SVH
`define DBE_ADDR_BANK_SEL   8'hE8
`define DBE_ADDR_CTRL       8'hEA
`define DBE_BANK_TOP        8'h3F
`define DBE_BIT_RAM_PAGE2   4
`define DBE_BIT_NVM_PAGE1   1
`define DBE_BIT_NVM_PAGE0   0
`define DBE_BIT_STANDBY     6
`define DBE_BIT_ROW_START   3
`define DBE_BIT_ROW_MODE    2
`define DBE_BIT_BUSY        1
`define DBE_BIT_WR_ENABLE   0
`define DBE_CTRL_RESET      8'h00
`define DBE_ROW_BYTES       8
`define DBE_PROG_CYCLES     100
`endif

// *** verilog/dbe_pkg.sv ***
package dbe_pkg;
   typedef enum logic [1:0]
   {
      DBE_IDLE,
      DBE_PROG_BYTE,
      DBE_PROG_ROW
   } dbe_state_t;
endpackage : dbe_pkg

// *** verilog/dbe_data_bank_eeprom_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dbe_defines.svh"

// Function
// - bank bit 4 maps ram page 2, bit 1 nvm page 1, bit 0 nvm page 0
// - selected bank appears at data addresses 00h to 3Fh
// - bank register write-only at E8h, reads return nothing meaningful
// - reset leaves bank register unchanged and undefined
// - interrupts and calls never alter the bank register
// - standby bit 6 disables the eeprom and drops it to low power
// - with no eeprom bank selected, eeprom accesses do nothing
// - busy bit 1 set while programming; accesses then aborted, cycle completes
// - idle eeprom reads like any data location, same timing; in row mode the code returns 00 instead
// - write enable bit 0 needed before any eeprom write starts programming
// - byte mode writes program the addressed byte directly
// - while busy, control writes ignored, only busy readable
// - setting row mode bit 2 clears the eight row latches
// - row address latched on first write; other rows give errors
// - row is eight bytes sharing A7..A3, A2..A0 select byte
// - row start bit 3 programs only bytes written since row mode entry
// - end of programming clears row mode and row start bits
// - row start sets only with write enable and row mode set
// - clearing row mode before start discards the latches
module dbe_data_bank_eeprom_control
#(
   parameter int PROG_CYCLES = `DBE_PROG_CYCLES,
   parameter int ROW_BYTES   = `DBE_ROW_BYTES
)
(
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   // cpu data space
   input  wire logic [7:0] i_addr,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   input  wire logic [7:0] i_wdata,
   output logic      [7:0] o_rdata,
   output logic            o_rvalid,
   // bank decode towards data memories
   output logic            o_ram_page2_sel,
   output logic            o_nvm_error,
   output logic            o_nvm_power_down
);

   localparam int CW = $clog2(PROG_CYCLES + 1);

   logic [7:0]  data_bank_select;
   logic [7:0]  nvm_mem [0:127];
   logic        nvm_standby;
   logic        nvm_write_enable;
   logic        row_mode_enable;
   logic        row_program_start;
   logic        row_valid;
   logic [4:0]  row_addr;
   logic [7:0]  row_data [0:ROW_BYTES-1];
   logic [ROW_BYTES-1:0] row_used;
   logic [CW-1:0] prog_count;
   logic [6:0]  byte_addr;
   logic [7:0]  byte_data;
   dbe_pkg::dbe_state_t state;

   logic        in_bank;
   logic        nvm_sel;
   logic [6:0]  nvm_addr;
   logic        nvm_busy;
   logic        nvm_ok;
   logic        ctrl_wr;
   logic        row_hit;
   logic        start_ok;
   logic        prog_done;
   logic        row_miss;
   logic        row_load;

   function automatic logic [6:0] nvm_index(input logic [7:0] bank, input logic [7:0] a);
      nvm_index = {bank[`DBE_BIT_NVM_PAGE1], a[5:0]};
   endfunction : nvm_index

   assign in_bank   = (i_addr <= `DBE_BANK_TOP);
   // only a lone nvm page bit counts as a selection
   assign nvm_sel   = (data_bank_select == 8'h01) || (data_bank_select == 8'h02);
   assign nvm_addr  = nvm_index(data_bank_select, i_addr);
   assign nvm_busy  = (state != dbe_pkg::DBE_IDLE);
   assign nvm_ok    = in_bank && nvm_sel && !nvm_standby && !nvm_busy;
   assign ctrl_wr   = i_wr && (i_addr == `DBE_ADDR_CTRL) && !nvm_busy;
   assign row_hit   = !row_valid || (row_addr[3:0] == nvm_addr[6:3]);
   assign row_miss  = row_mode_enable && !row_hit;
   // last cycle of a programming run
   assign prog_done = (state != dbe_pkg::DBE_IDLE) && (prog_count == CW'(1));
   // a write that lands in the row latches instead of the cells
   assign row_load  = i_wr && nvm_ok && row_mode_enable && !row_program_start && row_hit;
   assign start_ok  = ctrl_wr && i_wdata[`DBE_BIT_ROW_START]
                      && i_wdata[`DBE_BIT_WR_ENABLE] && i_wdata[`DBE_BIT_ROW_MODE]
                      && row_mode_enable;
   assign o_ram_page2_sel  = in_bank && (data_bank_select == 8'h10);
   assign o_nvm_power_down = nvm_standby;

   // no reset on purpose: contents survive chip reset
   always_ff @(posedge i_clk)
   begin
      if (i_wr && (i_addr == `DBE_ADDR_BANK_SEL))
      begin
         data_bank_select <= i_wdata;
      end
   end

   // standby level
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         nvm_standby <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         nvm_standby <= i_wdata[`DBE_BIT_STANDBY];
      end
   end

   // programming enable
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         nvm_write_enable <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         nvm_write_enable <= i_wdata[`DBE_BIT_WR_ENABLE];
      end
   end

   // row mode, dropped by hardware when a row run ends
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         row_mode_enable <= 1'b0;
      end
      else if (prog_done && state == dbe_pkg::DBE_PROG_ROW)
      begin
         row_mode_enable <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         row_mode_enable <= i_wdata[`DBE_BIT_ROW_MODE];
      end
   end

   // row start, only taken with enable in the same write and row mode already set
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         row_program_start <= 1'b0;
      end
      else if (prog_done && state == dbe_pkg::DBE_PROG_ROW)
      begin
         row_program_start <= 1'b0;
      end
      else if (ctrl_wr)
      begin
         row_program_start <= start_ok;
      end
   end

   // row latches
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         row_valid <= 1'b0;
         row_addr  <= 5'h00;
         row_used  <= '0;
      end
      else if (ctrl_wr && (i_wdata[`DBE_BIT_ROW_MODE] && !row_mode_enable ||
                           !i_wdata[`DBE_BIT_ROW_MODE]))
      begin
         row_valid <= 1'b0;
         row_used  <= '0;
      end
      else if (prog_done && state == dbe_pkg::DBE_PROG_ROW)
      begin
         row_valid <= 1'b0;
         row_used  <= '0;
      end
      else if (row_load)
      begin
         row_valid <= 1'b1;
         // top bit unused: the nvm index is seven bits wide
         row_addr  <= {1'b0, nvm_addr[6:3]};
         row_used[nvm_addr[2:0]] <= 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (row_load)
      begin
         row_data[nvm_addr[2:0]] <= i_wdata;
      end
   end

   // programming sequencer
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state      <= dbe_pkg::DBE_IDLE;
         prog_count <= '0;
      end
      else
      begin
         case (state)
            dbe_pkg::DBE_IDLE:
            begin
               if (start_ok)
               begin
                  state      <= dbe_pkg::DBE_PROG_ROW;
                  prog_count <= CW'(PROG_CYCLES);
               end
               else if (i_wr && nvm_ok && nvm_write_enable && !row_mode_enable)
               begin
                  state      <= dbe_pkg::DBE_PROG_BYTE;
                  prog_count <= CW'(PROG_CYCLES);
               end
            end
            dbe_pkg::DBE_PROG_BYTE,
            dbe_pkg::DBE_PROG_ROW:
            begin
               prog_count <= prog_count - CW'(1);
               if (prog_count == CW'(1))
               begin
                  state <= dbe_pkg::DBE_IDLE;
               end
            end
            default:
            begin
               state <= dbe_pkg::DBE_IDLE;
            end
         endcase
      end
   end

   // byte mode target, captured as the run starts
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         byte_addr <= 7'h00;
         byte_data <= 8'h00;
      end
      else if (state == dbe_pkg::DBE_IDLE && !start_ok &&
               i_wr && nvm_ok && nvm_write_enable && !row_mode_enable)
      begin
         byte_addr <= nvm_addr;
         byte_data <= i_wdata;
      end
   end

   // cells are committed at the end of the cycle
   always_ff @(posedge i_clk)
   begin
      if (prog_count == CW'(1) && state == dbe_pkg::DBE_PROG_BYTE)
      begin
         nvm_mem[byte_addr] <= byte_data;
      end
      else if (prog_count == CW'(1) && state == dbe_pkg::DBE_PROG_ROW)
      begin
         for (int i = 0; i < ROW_BYTES; i++)
         begin
            if (row_used[i])
            begin
               nvm_mem[{row_addr[3:0], 3'(i)}] <= row_data[i];
            end
         end
      end
   end

   // read strobe, one cycle like any data location
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rvalid <= 1'b0;
      end
      else
      begin
         // a wrong-row access in row mode is an error, never data
         o_rvalid <= i_rd && ((nvm_ok && !row_miss) || i_addr == `DBE_ADDR_CTRL);
      end
   end

   // aborted or misdirected eeprom access
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_nvm_error <= 1'b0;
      end
      else
      begin
         o_nvm_error <= (i_rd || i_wr) && in_bank && nvm_sel &&
                        (nvm_busy || nvm_standby || row_miss);
      end
   end

   // read data, held until the next read
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_rdata <= 8'h00;
      end
      else
      begin
         if (i_rd && i_addr == `DBE_ADDR_CTRL)
         begin
            o_rdata <= {6'h00, nvm_busy, 1'b0};
         end
         else if (i_rd && nvm_ok && !row_mode_enable)
         begin
            o_rdata <= nvm_mem[nvm_addr];
         end
         else if (i_rd)
         begin
            o_rdata <= 8'h00;
         end
      end
   end

endmodule : dbe_data_bank_eeprom_control
`default_nettype wire

// *** verif/dbe_cpu.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dbe_defines.svh"
module dbe_cpu
(
   // clock
   input  wire logic       i_clk,
   // data-space bus
   output logic      [7:0] o_addr,
   output logic            o_rd,
   output logic            o_wr,
   output logic      [7:0] o_wdata,
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid,
   input  wire logic       i_err,
   input  wire logic       i_sel
);
   logic [7:0] bank_image;
   logic [7:0] dq;
   logic       dv;
   logic       de;
   logic       ds;
   initial
   begin
      o_addr = 8'h00;
      o_rd = 1'b0;
      o_wr = 1'b0;
      o_wdata = 8'h00;
   end
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic v, output logic e, output logic s);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = d;
      o_rd = !w;
      o_wr = w;
      #1 s = i_sel;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_wr = 1'b0;
      // released data line shows no stale value
      o_wdata = ~d;
      q = i_rdata;
      v = i_rvalid;
      e = i_err;
   endtask : acc
   task bank(input logic [7:0] code);
      bank_image = code;
      acc(1'b1, `DBE_ADDR_BANK_SEL, code, dq, dv, de, ds);
   endtask : bank
   task ctrl(input logic [7:0] d);
      acc(1'b1, `DBE_ADDR_CTRL, d & 8'hCF, dq, dv, de, ds);
   endtask : ctrl
endmodule : dbe_cpu
`default_nettype wire

// *** verif/dbe_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dbe_defines.svh"
module dbe_chk
(
   input wire logic       i_clk,
   input wire logic       i_resetn,
   input wire logic [7:0] i_addr,
   input wire logic       i_rd,
   input wire logic       i_wr,
   input wire logic [7:0] o_rdata,
   input wire logic       o_rvalid,
   input wire logic       o_ram_page2_sel,
   input wire logic       o_nvm_error,
   input wire logic       o_nvm_power_down
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_ctrl_rd;
      i_rd && i_addr == `DBE_ADDR_CTRL;
   endsequence
   sequence s_ctrl_wr;
      i_wr && i_addr == `DBE_ADDR_CTRL;
   endsequence
   chk_ram_sel_range: assert property (o_ram_page2_sel |-> i_addr <= `DBE_BANK_TOP)
      else $error("page select outside bank window");
   chk_bank_rd_void: assert property (i_rd && i_addr == `DBE_ADDR_BANK_SEL |=> !o_rvalid)
      else $error("bank register read answered");
   chk_ctrl_rd_data: assert property (s_ctrl_rd |=> o_rvalid && (o_rdata & 8'hFD) == 8'h00)
      else $error("control read wrong");
   chk_standby_void: assert property (o_nvm_power_down && i_rd && i_addr <= 8'h3F |=> !o_rvalid)
      else $error("read answered in standby");
   chk_error_cause: assert property (o_nvm_error |-> $past(i_rd || i_wr) && $past(i_addr) <= 8'h3F)
      else $error("error without access");
   chk_error_no_data: assert property (o_nvm_error |-> !o_rvalid)
      else $error("aborted access gave data");
   chk_rvalid_cause: assert property (o_rvalid |-> $past(i_rd))
      else $error("data without read");
   chk_ram_no_nvm: assert property (o_ram_page2_sel && i_rd |=> !o_rvalid && !o_nvm_error)
      else $error("eeprom answered on ram page");
   chk_power_hold: assert property (not s_ctrl_wr |=> $stable(o_nvm_power_down))
      else $error("standby changed without write");
endmodule : dbe_chk
bind dbe_data_bank_eeprom_control dbe_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
   .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
   .o_ram_page2_sel(o_ram_page2_sel), .o_nvm_error(o_nvm_error),
   .o_nvm_power_down(o_nvm_power_down));
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dbe_defines.svh"
module testbench;
   logic       clk;
   logic       rstn;
   logic [7:0] addr, wdata, rdata, q, d;
   logic       rd, wr, rvalid, sel, err, pd, v, e, s;
   logic [7:0] mem [128];
   int         err_count, check_count, seed;
   int         row_q[$];
   dbe_data_bank_eeprom_control #(.PROG_CYCLES(4)) u_dut (.i_clk(clk), .i_resetn(rstn),
      .i_addr(addr), .i_rd(rd), .i_wr(wr), .i_wdata(wdata), .o_rdata(rdata),
      .o_rvalid(rvalid), .o_ram_page2_sel(sel), .o_nvm_error(err), .o_nvm_power_down(pd));
   dbe_cpu u_cpu (.i_clk(clk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata),
      .i_rdata(rdata), .i_rvalid(rvalid), .i_err(err), .i_sel(sel));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task finish_test;
      $display("checks=%0d mismatches=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   task rd_a(input logic [7:0] a);
      u_cpu.acc(1'b0, a, 8'($random(seed)), q, v, e, s);
   endtask : rd_a
   task wr_a(input logic [7:0] a, input logic [7:0] x);
      u_cpu.acc(1'b1, a, x, q, v, e, s);
   endtask : wr_a
   task wait_idle;
      rd_a(`DBE_ADDR_CTRL);
      for (int k = 0; k < 20 && q !== 8'h00; k++)
         rd_a(`DBE_ADDR_CTRL);
      chk(q, 8'h00);
   endtask : wait_idle
   // byte write, busy seen, aborted read, then read back
   task byte_wr(input int idx, input logic [7:0] a);
      d = $random(seed);
      wr_a(a, d);
      mem[idx] = d;
      rd_a(`DBE_ADDR_CTRL);
      chk(q, 8'h02);
      rd_a(a);
      chk({6'h00, v, e}, 8'h01);
      wait_idle();
      rd_a(a);
      chk(q, mem[idx]);
   endtask : byte_wr
   initial
   begin
      #100000;
      err_count++;
      finish_test();
   end
   initial
   begin
      seed = 4;
      err_count = 0;
      check_count = 0;
      rstn = 1'b0;
      repeat (16) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      rd_a(`DBE_ADDR_CTRL);
      chk(q, `DBE_CTRL_RESET);
      u_cpu.bank(8'h01);
      u_cpu.ctrl(8'h01);
      for (int i = 0; i < 8; i++)
         byte_wr(8 + i, 8'h08 + 8'(i));
      u_cpu.bank(8'h02);
      byte_wr(72, 8'h08);
      u_cpu.bank(8'h01);
      rd_a(8'h08);
      chk(q, mem[8]);
      $display("byte mode done");
      u_cpu.ctrl(8'h00);
      wr_a(8'h09, ~mem[9]);
      rd_a(`DBE_ADDR_CTRL);
      chk(q, 8'h00);
      u_cpu.ctrl(8'h05);
      row_q.delete();
      row_q = '{10, 12, 15};
      foreach (row_q[j])
      begin
         d = $random(seed);
         wr_a(8'(row_q[j]), d);
         mem[row_q[j]] = d;
      end
      wr_a(8'h10, 8'h5A);
      chk({7'h00, e}, 8'h01);
      u_cpu.ctrl(8'h0D);
      rd_a(`DBE_ADDR_CTRL);
      chk(q, 8'h02);
      wait_idle();
      for (int j = 8; j < 16; j++)
      begin
         rd_a(8'(j));
         chk(q, mem[j]);
      end
      byte_wr(11, 8'h0B);
      $display("row mode done");
      u_cpu.ctrl(8'h05);
      wr_a(8'h0E, ~mem[14]);
      u_cpu.ctrl(8'h01);
      u_cpu.ctrl(8'h09);
      rd_a(`DBE_ADDR_CTRL);
      chk(q, 8'h00);
      rd_a(8'h0E);
      chk(q, mem[14]);
      u_cpu.ctrl(8'h40);
      rd_a(8'h08);
      chk({6'h00, v, e}, 8'h01);
      chk({7'h00, pd}, 8'h01);
      u_cpu.ctrl(8'h00);
      @(negedge clk) rstn = 1'b0;
      @(negedge clk) rstn = 1'b1;
      rd_a(8'h08);
      chk(q, mem[8]);
      rd_a(`DBE_ADDR_BANK_SEL);
      chk({7'h00, v}, 8'h00);
      u_cpu.bank(8'h10);
      rd_a(8'h20);
      chk({6'h00, s, v}, 8'h02);
      rd_a(8'h50);
      chk({7'h00, s}, 8'h00);
      u_cpu.bank(8'h00);
      rd_a(8'h08);
      chk({6'h00, v, e}, 8'h00);
      $display("bank and standby done");
      finish_test();
   end
endmodule : testbench
`default_nettype wire
